// ### dvsldo_consts.svh
// Offsets, field positions, reset values and timing counts for the ramp and regulator registers.
// Assumes inclusion by bare name from the register module.
`ifndef DVSLDO_CONSTS_SVH
`define DVSLDO_CONSTS_SVH

// Register addresses
`define DVSLDO_ADDR_RAMP_RATE 8'h07
`define DVSLDO_ADDR_REG_VSEL 8'h08

// Field positions
`define DVSLDO_RATE_MSB 2
`define DVSLDO_FIRST_MSB 2
`define DVSLDO_FIRST_LSB 0
`define DVSLDO_SECOND_MSB 6
`define DVSLDO_SECOND_LSB 4

// Reset values and the immediate rate code
`define DVSLDO_RATE_RESET 3'h6
`define DVSLDO_RATE_IMMEDIATE 3'h7
`define DVSLDO_CORE_INIT 5'h14
`define DVSLDO_READ_IDLE 8'h00

// Regulator defaults per strap pair {strap_b, strap_a}; values arbitrary
`define DVSLDO_STRAP_DEF_0 8'h00
`define DVSLDO_STRAP_DEF_1 8'h11
`define DVSLDO_STRAP_DEF_2 8'h22
`define DVSLDO_STRAP_DEF_3 8'h33

// Timing: one core code step at the slowest rate
`define DVSLDO_CORE_STEP_UV 25000
`define DVSLDO_RATE0_UV_PER_US 150
`define DVSLDO_CLK_MHZ 250
`define DVSLDO_STEP_CYCLES_BASE ((`DVSLDO_CORE_STEP_UV * `DVSLDO_CLK_MHZ) / `DVSLDO_RATE0_UV_PER_US)

`endif

// ### dvsldo_pkg.sv
// Types shared by the ramp and regulator register block.
// Assumes the constants header is available by bare name.
package dvsldo_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} dvsldo_reg_req_t;

	typedef enum logic [1:0] {
		DVSLDO_IDLE = 2'b01,
		DVSLDO_RAMP = 2'b10
	} dvsldo_ramp_st_t;
endpackage : dvsldo_pkg

// ### dvsldo_step_timer.sv
// Step interval timer for the core voltage ramp.
// Assumes interval is at least one and stays steady while run is high.
`timescale 1ns/1ps
module dvsldo_step_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Control
	input wire logic run,
	input wire logic [15:0] interval,
	// Step pulse
	output logic tick
);
	logic [15:0] count;

	// Reload while idle so the first step waits a full interval
	always_ff @(posedge ref_clk) begin
		if (reset || !run) begin
			count <= interval;
		end else if (count <= 16'h0001) begin
			count <= interval;
		end else begin
			count <= count - 16'h0001;
		end
	end

	assign tick = run && (count <= 16'h0001);
endmodule : dvsldo_step_timer

// ### dvsldo_regs.sv
// Ramp rate and regulator voltage select registers with the core voltage ramp engine.
// Assumes a serial front end that presents decoded register accesses on ref_clk.
`timescale 1ns/1ps
`include "dvsldo_consts.svh"

module dvsldo_regs #(
	parameter int STEP_BASE_CYCLES = `DVSLDO_STEP_CYCLES_BASE
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Asynchronous pins
	input wire logic undervoltage_lockout,
	input wire logic regulator_default_strap_a,
	input wire logic regulator_default_strap_b,
	// Register access
	input wire dvsldo_pkg::dvsldo_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// Core ramp
	input wire logic ramp_start_set,
	input wire logic [4:0] core_target_code,
	output logic ramp_start,
	output logic [4:0] core_voltage_code,
	// Decoded settings
	output logic [2:0] ramp_rate_select,
	output logic [6:0] regulator_voltage_select,
	output logic [11:0] first_regulator_mv,
	output logic [11:0] second_regulator_mv
);
	logic [1:0] undervoltage_lockout_sync;
	logic lockout_seen;
	logic [1:0] strap_a_sync;
	logic [1:0] strap_b_sync;
	logic undervoltage_lockout_s;
	logic [1:0] strap_s;
	logic [7:0] strap_default;
	logic immediate;
	logic at_target;
	logic step_tick;
	logic timer_run;
	logic [15:0] step_interval;
	logic next_ramp_start;
	dvsldo_pkg::dvsldo_ramp_st_t state;
	dvsldo_pkg::dvsldo_ramp_st_t next_state;

	// Pins cross in; lockout sync stays clear so a plain reset never looks like lockout
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			undervoltage_lockout_sync <= 2'h0;
		end else begin
			undervoltage_lockout_sync <= {undervoltage_lockout_sync[0], undervoltage_lockout};
		end
	end

	always_ff @(posedge ref_clk) begin
		strap_a_sync <= {strap_a_sync[0], regulator_default_strap_a};
		strap_b_sync <= {strap_b_sync[0], regulator_default_strap_b};
	end

	assign undervoltage_lockout_s = undervoltage_lockout_sync[1];
	assign strap_s = {strap_b_sync[1], strap_a_sync[1]};

	always_comb begin
		unique case (strap_s)
			2'h0: strap_default = `DVSLDO_STRAP_DEF_0;
			2'h1: strap_default = `DVSLDO_STRAP_DEF_1;
			2'h2: strap_default = `DVSLDO_STRAP_DEF_2;
			2'h3: strap_default = `DVSLDO_STRAP_DEF_3;
		endcase
	end

	// Only lockout reloads; the general reset leaves settings alone
	always_ff @(posedge ref_clk) begin
		if (undervoltage_lockout_s) begin
			ramp_rate_select <= `DVSLDO_RATE_RESET;
		end else if (reg_req.write && reg_req.addr == `DVSLDO_ADDR_RAMP_RATE) begin
			ramp_rate_select <= reg_req.wdata[`DVSLDO_RATE_MSB:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (undervoltage_lockout_s) begin
			regulator_voltage_select <= {strap_default[`DVSLDO_SECOND_MSB:`DVSLDO_SECOND_LSB],
				1'b0, strap_default[`DVSLDO_FIRST_MSB:`DVSLDO_FIRST_LSB]};
		end else if (reg_req.write && reg_req.addr == `DVSLDO_ADDR_REG_VSEL) begin
			regulator_voltage_select <= {reg_req.wdata[`DVSLDO_SECOND_MSB:`DVSLDO_SECOND_LSB],
				1'b0, reg_req.wdata[`DVSLDO_FIRST_MSB:`DVSLDO_FIRST_LSB]};
		end
	end

	// Unused bits and unmapped addresses read as zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= `DVSLDO_READ_IDLE;
		end else if (reg_req.read) begin
			unique case (reg_req.addr)
				`DVSLDO_ADDR_RAMP_RATE: reg_rdata <= {5'h00, ramp_rate_select};
				`DVSLDO_ADDR_REG_VSEL: reg_rdata <= {1'b0, regulator_voltage_select};
				default: reg_rdata <= `DVSLDO_READ_IDLE;
			endcase
		end
	end

	// Regulator code to millivolts
	always_ff @(posedge ref_clk) begin
		unique case (regulator_voltage_select[`DVSLDO_FIRST_MSB:`DVSLDO_FIRST_LSB])
			3'h0: first_regulator_mv <= 12'h3E8;
			3'h1: first_regulator_mv <= 12'h44C;
			3'h2: first_regulator_mv <= 12'h546;
			3'h3: first_regulator_mv <= 12'h5DC;
			3'h4: first_regulator_mv <= 12'h898;
			3'h5: first_regulator_mv <= 12'hA28;
			3'h6: first_regulator_mv <= 12'hB22;
			3'h7: first_regulator_mv <= 12'hC4E;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		unique case (regulator_voltage_select[`DVSLDO_SECOND_MSB:`DVSLDO_SECOND_LSB])
			3'h0: second_regulator_mv <= 12'h41A;
			3'h1: second_regulator_mv <= 12'h4B0;
			3'h2: second_regulator_mv <= 12'h514;
			3'h3: second_regulator_mv <= 12'h708;
			3'h4: second_regulator_mv <= 12'h9C4;
			3'h5: second_regulator_mv <= 12'hAF0;
			3'h6: second_regulator_mv <= 12'hBB8;
			3'h7: second_regulator_mv <= 12'hCE4;
		endcase
	end

	// Rate doubles per code, so the interval halves; never below one cycle
	assign immediate = (ramp_rate_select == `DVSLDO_RATE_IMMEDIATE);
	always_comb begin
		step_interval = 16'(STEP_BASE_CYCLES >> ramp_rate_select);
		if (step_interval == 16'h0000) begin
			step_interval = 16'h0001;
		end
	end

	assign at_target = (core_voltage_code == core_target_code);
	assign timer_run = (state == dvsldo_pkg::DVSLDO_RAMP) && !immediate && !at_target;

	dvsldo_step_timer u_step_timer (
		.ref_clk(ref_clk),
		.reset(reset),
		.run(timer_run),
		.interval(step_interval),
		.tick(step_tick)
	);

	// A new start in the finishing cycle wins over the clear
	always_comb begin
		next_state = state;
		next_ramp_start = ramp_start;
		unique case (state)
			dvsldo_pkg::DVSLDO_IDLE: begin
				if (ramp_start_set) begin
					next_state = dvsldo_pkg::DVSLDO_RAMP;
					next_ramp_start = 1'b1;
				end
			end
			dvsldo_pkg::DVSLDO_RAMP: begin
				if (ramp_start_set) begin
					next_ramp_start = 1'b1;
				end else if (at_target) begin
					next_state = dvsldo_pkg::DVSLDO_IDLE;
					next_ramp_start = 1'b0;
				end
			end
			default: begin
				next_state = dvsldo_pkg::DVSLDO_IDLE;
				next_ramp_start = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= dvsldo_pkg::DVSLDO_IDLE;
			ramp_start <= 1'b0;
		end else begin
			state <= next_state;
			ramp_start <= next_ramp_start;
		end
	end

	// Code moves one step at a time on a step pulse, or jumps straight to the target at the immediate rate
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			core_voltage_code <= `DVSLDO_CORE_INIT;
		end else if (state == dvsldo_pkg::DVSLDO_RAMP && immediate) begin
			core_voltage_code <= core_target_code;
		end else if (step_tick) begin
			if (core_voltage_code < core_target_code) begin
				core_voltage_code <= 5'(core_voltage_code + 5'h01);
			end else begin
				core_voltage_code <= 5'(core_voltage_code - 5'h01);
			end
		end
	end

	// Assertion helper: settings stay unknown until the first lockout, so no reset here
	always_ff @(posedge ref_clk) begin
		if (undervoltage_lockout_s) begin
			lockout_seen <= 1'b1;
		end
	end

	sequence s_finishing;
		state == dvsldo_pkg::DVSLDO_RAMP && at_target && !ramp_start_set;
	endsequence

	sequence s_cleared;
		!ramp_start && state == dvsldo_pkg::DVSLDO_IDLE;
	endsequence

	a_rate_default: assert property (@(posedge ref_clk)
		undervoltage_lockout_s |=> ramp_rate_select == `DVSLDO_RATE_RESET)
		else $error("ramp rate not 06h after lockout");

	a_rate_readback: assert property (@(posedge ref_clk) disable iff (reset)
		reg_req.read && reg_req.addr == 8'h07 |=> reg_rdata == {5'h00, $past(ramp_rate_select)})
		else $error("ramp rate readback wrong");

	a_rate_immediate: assert property (@(posedge ref_clk) disable iff (reset)
		state == dvsldo_pkg::DVSLDO_RAMP && immediate |=> core_voltage_code == $past(core_target_code))
		else $error("immediate rate did not jump");

	a_reset_keeps: assert property (@(posedge ref_clk) disable iff (undervoltage_lockout_s)
		reset && lockout_seen && !reg_req.write
		|=> $stable(ramp_rate_select) && $stable(regulator_voltage_select))
		else $error("plain reset disturbed settings");

	a_vsel_layout: assert property (@(posedge ref_clk) disable iff (reset)
		reg_req.read && reg_req.addr == 8'h08 |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0
		&& reg_rdata[6:0] == $past(regulator_voltage_select))
		else $error("regulator select layout wrong");

	a_strap_load: assert property (@(posedge ref_clk)
		undervoltage_lockout_s |=> regulator_voltage_select == {$past(strap_default[6:4]), 1'b0, $past(strap_default[2:0])})
		else $error("strap default not loaded");

	a_first_map: assert property (@(posedge ref_clk)
		regulator_voltage_select[2:0] == 3'h2 |=> first_regulator_mv == 12'h546)
		else $error("first regulator decode wrong");

	a_second_map: assert property (@(posedge ref_clk)
		regulator_voltage_select[6:4] == 3'h0 |=> second_regulator_mv == 12'h41A)
		else $error("second regulator decode wrong");

	a_ramp_start: assert property (@(posedge ref_clk) disable iff (reset)
		state == dvsldo_pkg::DVSLDO_IDLE && ramp_start_set |=> ramp_start && state == dvsldo_pkg::DVSLDO_RAMP)
		else $error("ramp did not start");

	a_start_clear: assert property (@(posedge ref_clk) disable iff (reset)
		s_finishing |=> s_cleared)
		else $error("ramp start not cleared at target");

	a_step_single: assert property (@(posedge ref_clk) disable iff (reset)
		$past(state) == dvsldo_pkg::DVSLDO_RAMP && !$past(immediate) && !$past(reset)
		&& $changed(core_voltage_code) |-> $past(step_tick)
		&& (core_voltage_code == 5'($past(core_voltage_code) + 5'h01)
		|| core_voltage_code == 5'($past(core_voltage_code) - 5'h01)))
		else $error("core code moved by more than one step");
endmodule : dvsldo_regs

// ### dvsldo_host.sv
// Host model issuing decoded register accesses to the ramp and regulator block.
// Assumes the bench calls its tasks at falling edges of ref_clk.
`timescale 1ns/1ps
module dvsldo_host (
	// Clock
	input wire logic ref_clk,
	// Register request
	output dvsldo_pkg::dvsldo_reg_req_t req
);
	initial req = '0;

	// Idle edge after each access, so no strobe is set twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.addr = a;
		req.wdata = d;
		req.write = 1'b1;
		@(negedge ref_clk);
		req.write = 1'b0;
		@(negedge ref_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		req.addr = a;
		req.read = 1'b1;
		@(negedge ref_clk);
		req.read = 1'b0;
		@(negedge ref_clk);
	endtask : rd
endmodule : dvsldo_host

// ### tb_dvs_slew_and_ldo_voltage_regs.sv
// Self-checking bench for the ramp rate and regulator select registers.
// Assumes a small step base so rate-derived ramps finish quickly.
`timescale 1ns/1ps
module tb_dvs_slew_and_ldo_voltage_regs;
	localparam int BASE = 64;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic lockout = 1'b1;
	logic [1:0] strap;
	logic ramp_set = 1'b0;
	logic [4:0] tgt = 5'h14;
	dvsldo_pkg::dvsldo_reg_req_t req;
	logic [7:0] rdata;
	logic busy;
	logic [4:0] code;
	logic [2:0] rate;
	logic [6:0] vsel;
	logic [11:0] mv1;
	logic [11:0] mv2;
	logic rd_d = 1'b0;
	logic [7:0] q[$];
	int err_total = 0;
	int n_checks = 0;
	int seed = 19;
	logic [7:0] v;
	logic [7:0] dflt[4] = '{8'h00, 8'h11, 8'h22, 8'h33};
	logic [11:0] t1[8] = '{12'h3E8, 12'h44C, 12'h546, 12'h5DC, 12'h898, 12'hA28, 12'hB22, 12'hC4E};
	logic [11:0] t2[8] = '{12'h41A, 12'h4B0, 12'h514, 12'h708, 12'h9C4, 12'hAF0, 12'hBB8, 12'hCE4};

	always #2 ref_clk = ~ref_clk;

	dvsldo_host host (.ref_clk(ref_clk), .req(req));
	dvsldo_regs #(.STEP_BASE_CYCLES(BASE)) dut (.ref_clk(ref_clk), .reset(reset),
		.undervoltage_lockout(lockout), .regulator_default_strap_a(strap[0]),
		.regulator_default_strap_b(strap[1]), .reg_req(req), .reg_rdata(rdata),
		.ramp_start_set(ramp_set), .core_target_code(tgt), .ramp_start(busy),
		.core_voltage_code(code), .ramp_rate_select(rate),
		.regulator_voltage_select(vsel), .first_regulator_mv(mv1),
		.second_regulator_mv(mv2));

	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s exp %0h got %0h", nm, e, g);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		host.rd(a);
	endtask : rd

	// Read data lands one edge after the request is taken
	always @(posedge ref_clk) rd_d <= req.read;
	always @(negedge ref_clk) begin
		if (rd_d === 1'b1) begin
			if (q.size() == 0) chk("read queue", 12'h001, 12'h000);
			else chk("rdata", {4'h0, q.pop_front()}, {4'h0, rdata});
		end
	end

	task automatic lock(input logic [1:0] s);
		strap = s;
		lockout = 1'b1;
		repeat (12) @(negedge ref_clk);
		host.wr(8'h07, 8'h03);
		lockout = 1'b0;
		repeat (4) @(negedge ref_clk);
		rd(8'h07, 8'h06);
		rd(8'h08, dflt[s]);
	endtask : lock

	task automatic ramp(input logic [2:0] r, input logic [4:0] t);
		int n;
		int last;
		logic [4:0] prev;
		host.wr(8'h07, {5'h00, r});
		tgt = t;
		ramp_set = 1'b1;
		@(negedge ref_clk);
		ramp_set = 1'b0;
		chk("busy set", 12'h001, {11'h000, busy});
		prev = code;
		last = 0;
		for (n = 1; n < 3000 && busy !== 1'b0; n++) begin
			@(negedge ref_clk);
			if (code !== prev && r != 3'h7) begin
				chk("step", {7'h00, (t > prev) ? prev + 5'h01 : prev - 5'h01}, {7'h00, code});
				if (last != 0) chk("gap", 12'(BASE >> r), 12'(n - last));
				last = n;
				prev = code;
			end
		end
		if (busy !== 1'b0) begin
			chk("ramp timeout", 12'h000, {11'h000, busy});
			results();
		end
		chk("ramp end", {7'h00, t}, {7'h00, code});
		if (r == 3'h7) chk("immediate", 12'h003, 12'(n));
	endtask : ramp

	task automatic results;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results

	initial begin
		strap = 2'($random(seed));
		repeat (12) @(negedge ref_clk);
		reset = 1'b0;
		lock(strap);
		for (int i = 0; i < 8; i++) begin
			host.wr(8'h07, 8'(i));
			rd(8'h07, 8'(i));
			chk("rate out", 12'(i), {9'h000, rate});
			v = 8'($random(seed));
			host.wr(8'h08, v);
			rd(8'h08, v & 8'h77);
			chk("vsel", {5'h00, v[6:4], 1'b0, v[2:0]}, {5'h00, vsel});
			chk("first mv", t1[v[2:0]], mv1);
			chk("second mv", t2[v[6:4]], mv2);
		end
		host.wr(8'h09, 8'hFF);
		rd(8'h09, 8'h00);
		rd(8'h07, 8'h07);
		reset = 1'b1;
		repeat (3) @(negedge ref_clk);
		reset = 1'b0;
		@(negedge ref_clk);
		rd(8'h07, 8'h07);
		rd(8'h08, v & 8'h77);
		lock(~strap);
		ramp(3'h7, 5'h18);
		ramp(3'h6, 5'h1B);
		ramp(3'h2, 5'h18);
		ramp(3'h0, 5'h16);
		ramp(3'h5, 5'h16);
		repeat (4) @(negedge ref_clk);
		results();
	end
endmodule : tb_dvs_slew_and_ldo_voltage_regs
